// ---- pld_input_pkg.sv ----
// constants, register map and term layout of the configurable input path
package pld_input_pkg;
  localparam int NUM_DED   = 13;
  localparam int NUM_IO    = 12;
  localparam int NUM_CELLS = 25;
  localparam int NUM_SUM   = 192;
  localparam int NUM_TERMS = 216;
  localparam int MAX_PER   = 19;
  localparam int POL_BASE  = 192;
  localparam int OE_BASE   = 204;
  localparam int CELL_CLK_FIRST  = 0;
  localparam int CELL_CLK_SECOND = 1;
  localparam int CELL_GLOBAL_OE  = 12;
  // per-cell configuration word fields
  localparam int CFG_W       = 5;
  localparam int BIT_STORAGE = 0;
  localparam int BIT_PATH    = 1;
  localparam int BIT_SRC     = 2;
  localparam int BIT_POL     = 3;
  localparam int BIT_ENSRC   = 4;
  // byte offsets on the bus
  localparam logic [11:0] ADDR_CFG_LAST = 12'h060;
  localparam logic [11:0] ADDR_IN_STAT  = 12'h080;
  localparam logic [11:0] ADDR_OUT_STAT = 12'h084;
  localparam logic [11:0] ADDR_OE_STAT  = 12'h088;
  localparam logic [11:0] ADDR_TERM_LO  = 12'h800;
  localparam logic [11:0] ADDR_TERM_HI  = 12'hEBC;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] RDATA_ZERO    = 32'h00000000;
  // product terms per output sum
  localparam int TERM_COUNT [NUM_IO] = '{9, 19, 11, 17, 13, 15, 15, 13, 17, 11, 19, 9};
  function automatic int term_base(input int k);
    int s;
    s = 0;
    for (int j = 0; j < k; j++) begin
      s = s + TERM_COUNT[j];
    end
    return s;
  endfunction
endpackage

// ---- input_cell.sv ----
// one configurable array-input cell: register, latch or transparent path
`timescale 1ns/1ps
module input_cell (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // data and selected clock (already synchronised)
  input  wire logic din,
  input  wire logic clk_lvl,
  input  wire logic clk_prev,
  // configuration bits
  input  wire logic storage_enable_bit,
  input  wire logic path_select_bit,
  input  wire logic clock_polarity_bit,
  // value seen by the array
  output logic      array_in
);
  typedef struct packed {
    logic held;
  } cell_state_type;

  cell_state_type s_q;
  cell_state_type s_d;
  logic           reg_mode;
  logic           latch_mode;
  logic           active;
  logic           cap_edge;

  // mode decode; the unsupported pairing falls to transparent
  assign reg_mode   = storage_enable_bit & path_select_bit;
  assign latch_mode = ~storage_enable_bit & path_select_bit;
  assign active     = clk_lvl ^ clock_polarity_bit;
  assign cap_edge   = clock_polarity_bit ? (clk_prev & ~clk_lvl)
                                         : (~clk_prev & clk_lvl);

  // next held value
  always_comb begin
    s_d = s_q;
    if (reg_mode && cap_edge) begin
      s_d.held = din;
    end else if (latch_mode && active) begin
      s_d.held = din;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // open latch and transparent path show the live input
  assign array_in = (reg_mode || (latch_mode && !active)) ? s_q.held : din;

  sequence s_closed2;
    latch_mode && !active ##1 latch_mode && !active;
  endsequence

  property p_reg_capture;
    @(posedge core_clk) disable iff (rst) (reg_mode && cap_edge) ##1 reg_mode |-> array_in == $past(din);
  endproperty
  a_reg_capture: assert property (p_reg_capture) else $error("register missed edge");

  property p_reg_hold;
    @(posedge core_clk) disable iff (rst) (reg_mode && !cap_edge) ##1 reg_mode |-> $stable(array_in);
  endproperty
  a_reg_hold: assert property (p_reg_hold) else $error("register changed without edge");

  property p_latch_open;
    @(posedge core_clk) disable iff (rst) latch_mode && active |-> array_in == din;
  endproperty
  a_latch_open: assert property (p_latch_open) else $error("open latch not following");

  property p_latch_hold;
    @(posedge core_clk) disable iff (rst) s_closed2 |-> $stable(array_in);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("closed latch changed");

  property p_transparent;
    @(posedge core_clk) disable iff (rst) !path_select_bit |-> array_in == din;
  endproperty
  a_transparent: assert property (p_transparent) else $error("transparent path broken");
endmodule

// ---- output_cell.sv ----
// one output cell: term sum, polarity term and enable selection
`timescale 1ns/1ps
module output_cell #(
  parameter int NTERMS = 9
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // product terms
  input  wire logic [NTERMS-1:0] sum_terms,
  input  wire logic              pol_term,
  input  wire logic              oe_term,
  // enable choice
  input  wire logic              global_oe,
  input  wire logic              enable_source_bit,
  // pin drive
  output logic                   out_q,
  output logic                   oe_q
);
  typedef struct packed {
    logic out;
    logic oe;
  } out_state_type;

  out_state_type s_q;
  out_state_type s_d;

  // sum, polarity flip and enable choice
  always_comb begin
    s_d     = s_q;
    s_d.out = (|sum_terms) ^ pol_term;
    s_d.oe  = enable_source_bit ? global_oe : oe_term;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign out_q = s_q.out;
  assign oe_q  = s_q.oe;

  property p_oe_select;
    @(posedge core_clk) disable iff (rst)
      !rst |=> oe_q == ($past(enable_source_bit) ? $past(global_oe) : $past(oe_term));
  endproperty
  a_oe_select: assert property (p_oe_select) else $error("wrong enable source");

  property p_polarity;
    @(posedge core_clk) disable iff (rst) !rst |=> out_q == ((|$past(sum_terms)) ^ $past(pol_term));
  endproperty
  a_polarity: assert property (p_polarity) else $error("output polarity wrong");
endmodule

// ---- pld_input_top.sv ----
// configurable logic device: input cells, term array and AHB-Lite config port
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module pld_input_top
  import pld_input_pkg::*;
(
  // clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                rst,
  // AHB-Lite slave
  input  wire logic                                hsel,
  input  wire logic [31:0]                         haddr,
  input  wire logic [1:0]                          htrans,
  input  wire logic                                hwrite,
  input  wire logic [2:0]                          hsize,
  input  wire logic [31:0]                         hwdata,
  input  wire logic                                hready,
  output logic      [31:0]                         hrdata,
  output logic                                     hreadyout,
  output logic                                     hresp,
  // dedicated input pins
  input  wire logic [pld_input_pkg::NUM_DED-1:0]   ded_pin,
  // bidirectional pins
  input  wire logic [pld_input_pkg::NUM_IO-1:0]    io_pin_in,
  output logic      [pld_input_pkg::NUM_IO-1:0]    io_pin_out,
  output logic      [pld_input_pkg::NUM_IO-1:0]    io_pin_oe
);
  import pld_input_pkg::*;

  // cells and codes probed by the mode checks below
  localparam int               PROBE_RISE      = 2;
  localparam int               PROBE_FALL      = 3;
  localparam int               PROBE_LATCH     = 4;
  localparam logic [3:0]       MODE_REG_RISE   = 4'h3;
  localparam logic [3:0]       MODE_REG_FALL   = 4'hB;
  localparam logic [3:0]       MODE_REG_SECOND = 4'h7;
  localparam logic [3:0]       MODE_LATCH_LOW  = 4'hA;
  localparam logic [11:0]      ADDR_CFG_FIRST  = 12'h000;

  typedef struct packed {
    logic [NUM_DED-1:0]                ded_s1;
    logic [NUM_DED-1:0]                ded_s2;
    logic [1:0]                        clk_p;
    logic [NUM_IO-1:0]                 io_s1;
    logic [NUM_IO-1:0]                 io_s2;
    logic [NUM_CELLS-1:0][CFG_W-1:0]   cfg;
    logic [NUM_TERMS-1:0][NUM_CELLS-1:0] tmask;
    logic [NUM_TERMS-1:0][NUM_CELLS-1:0] cmask;
    logic                              wr_pend;
    logic [11:0]                       wr_addr;
    logic [31:0]                       rdata;
  } top_state_type;

  top_state_type          s_q;
  top_state_type          s_d;
  logic [NUM_CELLS-1:0]   array_in;
  logic [NUM_CELLS-1:0]   cell_din;
  logic [NUM_TERMS-1:0]   term;
  logic                   clk_first;
  logic                   clk_second;
  logic                   global_oe;
  logic                   phase_ok;
  logic [11:0]            ra;
  logic [7:0]             tidx;
  logic [7:0]             widx;

  // both clock pins and the enable pin come from synchronised levels
  assign clk_first  = s_q.ded_s2[CELL_CLK_FIRST];
  assign clk_second = s_q.ded_s2[CELL_CLK_SECOND];
  assign global_oe  = s_q.ded_s2[CELL_GLOBAL_OE];
  assign cell_din   = {s_q.io_s2, s_q.ded_s2};

  // one cell per array input; clock pins cross-clock each other
  generate
    for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
      logic use_second;
      if (i == CELL_CLK_FIRST) begin : g_c0
        assign use_second = 1'b1;
      end else if (i == CELL_CLK_SECOND) begin : g_c1
        assign use_second = 1'b0;
      end else begin : g_cn
        assign use_second = s_q.cfg[i][BIT_SRC];
      end
      input_cell u_cell (
        .core_clk           (core_clk),
        .rst                (rst),
        .din                (cell_din[i]),
        .clk_lvl            (use_second ? clk_second : clk_first),
        .clk_prev           (use_second ? s_q.clk_p[1] : s_q.clk_p[0]),
        .storage_enable_bit (s_q.cfg[i][BIT_STORAGE]),
        .path_select_bit    (s_q.cfg[i][BIT_PATH]),
        .clock_polarity_bit (s_q.cfg[i][BIT_POL]),
        .array_in           (array_in[i])
      );
    end
  endgenerate

  // product terms: and of selected true and complement inputs
  generate
    for (genvar t = 0; t < NUM_TERMS; t++) begin : g_term
      assign term[t] = &((array_in | ~s_q.tmask[t]) & (~array_in | ~s_q.cmask[t]));
    end
  endgenerate

  // output cells with position-dependent term counts
  generate
    for (genvar k = 0; k < NUM_IO; k++) begin : g_out
      localparam int B = term_base(k);
      localparam int N = TERM_COUNT[k];
      output_cell #(.NTERMS(N)) u_out (
        .core_clk          (core_clk),
        .rst               (rst),
        .sum_terms         (term[B +: N]),
        .pol_term          (term[POL_BASE + k]),
        .oe_term           (term[OE_BASE + k]),
        .global_oe         (global_oe),
        .enable_source_bit (s_q.cfg[NUM_DED + k][BIT_ENSRC]),
        .out_q             (io_pin_out[k]),
        .oe_q              (io_pin_oe[k])
      );

      // each output pin against its own terms and enable choice
      property p_sum_out;
        @(posedge core_clk) disable iff (rst)
          !rst |=> io_pin_out[k] == ((|$past(term[B +: N])) ^ $past(term[POL_BASE + k]));
      endproperty
      a_sum_out: assert property (p_sum_out) else $error("output sum wrong");

      property p_local_oe;
        @(posedge core_clk) disable iff (rst)
          !rst && !s_q.cfg[NUM_DED + k][BIT_ENSRC] |=> io_pin_oe[k] == $past(term[OE_BASE + k]);
      endproperty
      a_local_oe: assert property (p_local_oe) else $error("local enable not used");

      property p_global_oe;
        @(posedge core_clk) disable iff (rst)
          !rst && s_q.cfg[NUM_DED + k][BIT_ENSRC] |=> io_pin_oe[k] == $past(global_oe);
      endproperty
      a_global_oe: assert property (p_global_oe) else $error("global enable not used");
    end
  endgenerate

  // bus address phase decode
  assign phase_ok = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign ra       = haddr[11:0];
  assign tidx     = 8'(ra[10:3]);
  assign widx     = 8'(s_q.wr_addr[10:3]);

  // next state: synchronisers, config writes, read data
  always_comb begin
    s_d        = s_q;
    s_d.ded_s1 = ded_pin;
    s_d.ded_s2 = s_q.ded_s1;
    s_d.clk_p  = {clk_second, clk_first};
    s_d.io_s1  = io_pin_in;
    s_d.io_s2  = s_q.io_s1;
    s_d.wr_pend = phase_ok & hwrite;
    if (phase_ok) begin
      s_d.wr_addr = ra;
    end
    // data phase of a write
    if (s_q.wr_pend) begin
      if (s_q.wr_addr <= ADDR_CFG_LAST && s_q.wr_addr[1:0] == 2'h0) begin
        s_d.cfg[s_q.wr_addr[6:2]] = hwdata[CFG_W-1:0];
      end else if (s_q.wr_addr >= ADDR_TERM_LO && s_q.wr_addr <= ADDR_TERM_HI) begin
        if (s_q.wr_addr[2]) begin
          s_d.cmask[widx] = hwdata[NUM_CELLS-1:0];
        end else begin
          s_d.tmask[widx] = hwdata[NUM_CELLS-1:0];
        end
      end
    end
    // read data prepared in the address phase
    s_d.rdata = RDATA_ZERO;
    if (phase_ok && !hwrite) begin
      if (ra <= ADDR_CFG_LAST && ra[1:0] == 2'h0) begin
        s_d.rdata = {27'h0000000, s_q.cfg[ra[6:2]]};
      end else if (ra == ADDR_IN_STAT) begin
        s_d.rdata = {7'h00, array_in};
      end else if (ra == ADDR_OUT_STAT) begin
        s_d.rdata = {20'h00000, io_pin_out};
      end else if (ra == ADDR_OE_STAT) begin
        s_d.rdata = {20'h00000, io_pin_oe};
      end else if (ra >= ADDR_TERM_LO && ra <= ADDR_TERM_HI) begin
        s_d.rdata = {7'h00, ra[2] ? s_q.cmask[tidx] : s_q.tmask[tidx]};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // zero-wait slave, always OKAY
  assign hrdata    = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  property p_clk_cross0;
    @(posedge core_clk) disable iff (rst)
      (s_q.cfg[CELL_CLK_FIRST][BIT_PATH] && s_q.cfg[CELL_CLK_FIRST][BIT_STORAGE]
       && !s_q.cfg[CELL_CLK_FIRST][BIT_POL] && !s_q.clk_p[1] && clk_second)
      ##1 $stable(s_q.cfg) |-> array_in[CELL_CLK_FIRST] == $past(cell_din[CELL_CLK_FIRST]);
  endproperty
  a_clk_cross0: assert property (p_clk_cross0) else $error("first clock cell not on second pin");

  property p_goe_pin;
    @(posedge core_clk) disable iff (rst) global_oe == $past(ded_pin[CELL_GLOBAL_OE], 2);
  endproperty
  a_goe_pin: assert property (p_goe_pin) else $error("global enable not from its pin");

  property p_clkpin_array;
    @(posedge core_clk) disable iff (rst)
      !s_q.cfg[CELL_CLK_SECOND][BIT_PATH]
      |-> array_in[CELL_CLK_SECOND] == $past(ded_pin[CELL_CLK_SECOND], 2);
  endproperty
  a_clkpin_array: assert property (p_clkpin_array) else $error("clock pin not in array");

  property p_bus_read;
    @(posedge core_clk) disable iff (rst)
      phase_ok && !hwrite && ra == ADDR_IN_STAT |=> hrdata == {7'h00, $past(array_in)};
  endproperty
  a_bus_read: assert property (p_bus_read) else $error("status read wrong");

  property p_io_direct;
    @(posedge core_clk) disable iff (rst)
      !s_q.cfg[NUM_DED][BIT_PATH] |-> array_in[NUM_DED] == $past(io_pin_in[0], 2);
  endproperty
  a_io_direct: assert property (p_io_direct) else $error("io direct input wrong");

  // synchronised clock-pin edges as the cells see them
  sequence s_first_rise;
    !s_q.clk_p[CELL_CLK_FIRST] && clk_first;
  endsequence
  sequence s_first_fall;
    s_q.clk_p[CELL_CLK_FIRST] && !clk_first;
  endsequence
  sequence s_second_rise;
    !s_q.clk_p[CELL_CLK_SECOND] && clk_second;
  endsequence

  property p_clk_cross1;
    @(posedge core_clk) disable iff (rst)
      (s_q.cfg[CELL_CLK_SECOND][BIT_PATH] && s_q.cfg[CELL_CLK_SECOND][BIT_STORAGE]
       && s_q.cfg[CELL_CLK_SECOND][BIT_POL]) ##0 s_first_fall
      ##1 $stable(s_q.cfg)
      |-> array_in[CELL_CLK_SECOND] == $past(cell_din[CELL_CLK_SECOND]);
  endproperty
  a_clk_cross1: assert property (p_clk_cross1) else $error("second clock cell not on first pin");

  property p_reg_first;
    @(posedge core_clk) disable iff (rst)
      (s_q.cfg[PROBE_RISE][BIT_POL:0] == MODE_REG_RISE) ##0 s_first_rise
      ##1 $stable(s_q.cfg)
      |-> array_in[PROBE_RISE] == $past(cell_din[PROBE_RISE]);
  endproperty
  a_reg_first: assert property (p_reg_first) else $error("first pin register missed edge");

  property p_reg_fall;
    @(posedge core_clk) disable iff (rst)
      (s_q.cfg[PROBE_FALL][BIT_POL:0] == MODE_REG_FALL) ##0 s_first_fall
      ##1 $stable(s_q.cfg)
      |-> array_in[PROBE_FALL] == $past(cell_din[PROBE_FALL]);
  endproperty
  a_reg_fall: assert property (p_reg_fall) else $error("falling edge register missed");

  property p_reg_second;
    @(posedge core_clk) disable iff (rst)
      (s_q.cfg[NUM_DED][BIT_POL:0] == MODE_REG_SECOND) ##0 s_second_rise
      ##1 $stable(s_q.cfg)
      |-> array_in[NUM_DED] == $past(cell_din[NUM_DED]);
  endproperty
  a_reg_second: assert property (p_reg_second) else $error("io register not on second pin");

  property p_latch_low;
    @(posedge core_clk) disable iff (rst)
      s_q.cfg[PROBE_LATCH][BIT_POL:0] == MODE_LATCH_LOW && !clk_first
      |-> array_in[PROBE_LATCH] == cell_din[PROBE_LATCH];
  endproperty
  a_latch_low: assert property (p_latch_low) else $error("low latch not open");

  property p_cfg_write;
    @(posedge core_clk) disable iff (rst)
      s_q.wr_pend && s_q.wr_addr == ADDR_CFG_FIRST
      |=> s_q.cfg[CELL_CLK_FIRST] == $past(hwdata[CFG_W-1:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

  property p_cfg_read;
    @(posedge core_clk) disable iff (rst)
      phase_ok && !hwrite && ra == ADDR_CFG_FIRST
      |=> hrdata == {27'h0000000, $past(s_q.cfg[CELL_CLK_FIRST])};
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");
endmodule

// ---- pld_pin_model.sv ----
// external logic model driving the dedicated and bidirectional pins
`timescale 1ns/1ps
module pld_pin_model (
  // clock
  input  wire logic        core_clk,
  // pin drive
  output logic      [12:0] ded_pin,
  output logic      [11:0] io_pin_in
);
  // both clock pins idle low
  initial begin
    ded_pin   = 13'h0000;
    io_pin_in = 12'h000;
  end
  // change pins after an edge, then hold each level well past the synchroniser
  task automatic apply(input logic [12:0] d, input logic [11:0] io);
    @(posedge core_clk);
    ded_pin   <= d;
    io_pin_in <= io;
    repeat (6) @(posedge core_clk);
  endtask
endmodule

// ---- pld_input_macrocell_config_tb_top.sv ----
// self-checking bench for the configurable input path and its register port
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pld_input_macrocell_config_tb_top;
  import pld_input_pkg::*;
  // bus drive and design outputs
  logic        core_clk;
  logic        rst    = 1'b1;
  logic        hsel   = 1'b0;
  logic [31:0] haddr  = 32'h00000000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize  = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [12:0] ded_pin;
  logic [11:0] io_drive;
  logic [11:0] io_pin_out;
  logic [11:0] io_pin_oe;
  // the device wins the shared pin while it drives
  wire  [11:0] io_wire = (io_pin_oe & io_pin_out) | (~io_pin_oe & io_drive);
  // bench state
  int          fail_count = 0;
  int          tests_run  = 0;
  int          seed       = 5;
  logic [4:0]  cfg [25]   = '{default: 5'h00};
  logic [24:0] exp_in     = 25'h0000000;
  logic [12:0] ded_v      = 13'h0000;
  logic [11:0] x_v        = 12'h000;
  logic [11:0] w_v        = 12'h000;
  logic [11:0] oe_v       = 12'h000;
  logic [31:0] expq [$];
  logic [31:0] want;
  logic        rd_dp      = 1'b0;

  pld_input_top pld_input_top_i (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ded_pin(ded_pin),
    .io_pin_in(io_wire), .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe));
  pld_pin_model pld_pin_model_i (.core_clk(core_clk), .ded_pin(ded_pin), .io_pin_in(io_drive));

  // free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // one single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {20'h00000, a};
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask

  // note the expected word, then read it
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h00000000);
  endtask

  // compare each read data phase with the oldest note
  always @(posedge core_clk) begin
    if (rd_dp) begin
      want = expq.pop_front();
      `CHK(hrdata, want)
      `CHK({31'h00000000, hresp}, 32'h00000000)
    end
    rd_dp <= hsel && htrans == HTRANS_NONSEQ && !hwrite && hreadyout;
  end

  // work out the array inputs after one pin change
  task automatic predict(input logic [12:0] d1, input logic [11:0] x1);
    logic [24:0] p0;
    logic [24:0] p1;
    logic [4:0]  c;
    logic        c0;
    logic        c1;
    logic        hit;
    p0 = {w_v, ded_v};
    p1 = {12'h000, d1};
    for (int i = 0; i < 25; i++) begin
      if (i == 13) begin
        for (int k = 0; k < 12; k++) oe_v[k] = cfg[13 + k][4] & d1[12];
        w_v = (oe_v & {10'h000, exp_in[4], !exp_in[3]}) | (~oe_v & x1);
        p1[24:13] = w_v;
      end
      c = cfg[i];
      c0 = (i == 1 || (i > 1 && !c[2])) ? ded_v[0] : ded_v[1];
      c1 = (i == 1 || (i > 1 && !c[2])) ? d1[0] : d1[1];
      hit = c[3] ? (c0 && !c1) : (!c0 && c1);
      if (!c[1]) exp_in[i] = p1[i];
      else if (c[0]) begin
        if (hit) exp_in[i] = p0[i];
      end else if (c[3] ^ c1) exp_in[i] = p1[i];
    end
    ded_v = d1;
  endtask

  // move data or one clock pin, then check inputs, outputs and enables
  task automatic step(input int k, input logic chk);
    logic [31:0] r;
    logic [12:0] d;
    r = $random(seed);
    d = ded_v;
    if (k == 0) begin
      d[12:2] = r[10:0];
      x_v = r[22:11];
    end else begin
      d[k - 1] = !d[k - 1];
    end
    predict(d, x_v);
    pld_pin_model_i.apply(d, x_v);
    if (chk) begin
      rd(ADDR_IN_STAT, {7'h00, exp_in});
      rd(ADDR_OUT_STAT, {30'h00000000, exp_in[4], !exp_in[3]});
      rd(ADDR_OE_STAT, {20'h00000, oe_v});
    end
  endtask

  // verdict and end of run
  task automatic summarize();
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (10000) @(posedge core_clk);
    fail_count++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(12'h000, 32'h00000000);
    rd(ADDR_OUT_STAT, 32'h00000000);
    rd(ADDR_OE_STAT, 32'h00000FFF);
    bus(1'b1, 12'h0C0, 32'hFFFFFFFF);
    rd(12'h0C0, 32'h00000000);
    // output 0 flipped by input 3, output 1 left with its last term, local enables off
    bus(1'b1, ADDR_TERM_LO + 12'(8 * 192), 32'h00000008);
    for (int t = 9; t < 216; t++) begin
      if (t < 27 || t > 203) begin
        bus(1'b1, ADDR_TERM_LO + 12'(8 * t), 32'h00000004);
        bus(1'b1, ADDR_TERM_LO + 12'(8 * t + 4), 32'h00000004);
      end
    end
    bus(1'b1, ADDR_TERM_LO + 12'(8 * 27 + 4), 32'h00000010);
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 25; i++) begin
        cfg[i] = 5'($random(seed));
        if (cfg[i][1:0] == 2'b01) cfg[i][1] = 1'b1;
        if (r == 0 && i < 2) cfg[i] = (i == 0) ? 5'h03 : 5'h0B;
        bus(1'b1, 12'(4 * i), {27'h0000000, cfg[i]});
      end
      for (int p = 0; p < 8; p++) step(1 + (p / 2) % 2, 1'b0);
      for (int s = 0; s < 12; s++) step($unsigned($random(seed)) % 3, 1'b1);
    end
    @(posedge core_clk);
    summarize();
  end
endmodule
